// File: shared/plb_consts.vh
// constants for the logic block, routing matrix and scan port
`ifndef PLB_CONSTS_VH
`define PLB_CONSTS_VH
`define PLB_NSIG 36
`define PLB_NIN 72
`define PLB_NPT 87
`define PLB_NGEN 80
`define PLB_NMC 16
`define PLB_NIO 8
`define PLB_NSRC 28
`define PLB_NPIN 15
`define PLB_PT_OE0 80
`define PLB_PT_SET 84
`define PLB_PT_CLR 85
`define PLB_PT_CLK 86
// register byte addresses and region tags
`define PLB_A_TERM_END 12'h570
`define PLB_R_ALLOC 4'h6
`define PLB_R_MCFG 6'h1c
`define PLB_A_POL 12'h740
`define PLB_A_USER 12'h744
`define PLB_R_RSEL 4'h9
`define PLB_A_PINS 12'ha00
`define PLB_A_MCST 12'ha04
`define PLB_TERM_W2_MASK 32'h0000_00ff
`define PLB_ALLOC_W2_MASK 32'h0000_ffff
// macrocell config bits
`define PLB_MC_REG 0
`define PLB_MC_LAT 1
`define PLB_MC_INV 2
`define PLB_MC_OESEL 3
`define PLB_MC_INREG 4
`define PLB_MC_SLOW 5
`define PLB_MC_PTCLK 6
`define PLB_MCFG_W 7
// polarity bits: oe 0..3, set 4, clear 5, clock 6, share 7
`define PLB_POL_SET 4
`define PLB_POL_CLR 5
`define PLB_POL_CLK 6
`define PLB_POL_SHARE 7
// scan port
`define PLB_IR_EXTEST 4'h0
`define PLB_IR_SAMPLE 4'h1
`define PLB_IR_IDCODE 4'h2
`define PLB_IR_USER 4'h3
`define PLB_IR_CFG 4'h8
`define PLB_IR_BYPASS 4'hf
`define PLB_IR_CAPT 4'h1
`define PLB_DR_W 44
`define PLB_LEN_BYP 6'd1
`define PLB_LEN_BSR 6'd16
`define PLB_LEN_ID 6'd32
`define PLB_LEN_CFG 6'd44
// arbitrary neutral identity value
`define PLB_IDCODE 32'h1000_0001
`endif

// File: hw/plb_macrocell.v
// one macrocell: sum/input register, latch mode, set/clear, polarity
`timescale 1ns/100ps
`include "plb_consts.vh"
module plb_macrocell (
  input  wire                   ref_clk,
  input  wire                   rst_b,
  input  wire [`PLB_MCFG_W-1:0] cfg,      // macrocell config
  input  wire                   sum,      // or of granted terms
  input  wire                   pin_in,   // synced neighbour pin
  input  wire                   set_t,    // async set term
  input  wire                   clr_t,    // async clear term
  input  wire                   pin_rise, // pin clock edge
  input  wire                   pin_lvl,  // pin clock level
  input  wire                   pt_rise,  // term clock edge
  input  wire                   pt_lvl,   // term clock level
  output reg                    state_q,  // feedback value
  output wire                   result    // polarity-adjusted output
);
  wire d_in;
  wire edge_hit;
  wire lvl_hit;

  // input register mode takes the pin instead of the sum
  assign d_in = cfg[`PLB_MC_INREG] ? pin_in : sum; // [RULE9]
  // clock from the pin or from the clock term
  assign edge_hit = cfg[`PLB_MC_PTCLK] ? pt_rise : pin_rise; // [RULE7]
  assign lvl_hit = cfg[`PLB_MC_PTCLK] ? pt_lvl : pin_lvl;
  // active-high or active-low drive of the result
  assign result = state_q ^ cfg[`PLB_MC_INV]; // [RULE11]

  // set/clear emulated at clock rate; clear wins over set
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= 1'b0;
    else if (clr_t)
      state_q <= 1'b0; // [RULE6]
    else if (set_t)
      state_q <= 1'b1; // [RULE6]
    else if (!cfg[`PLB_MC_REG])
      state_q <= d_in; // combinational mode, one cycle late
    else if (cfg[`PLB_MC_LAT])
    begin
      if (lvl_hit)
        state_q <= d_in; // transparent latch [RULE9]
    end
    else if (edge_hit)
      state_q <= d_in; // edge register [RULE9]
  end
endmodule

// File: hw/plb_logic_block.v
// logic block with routing matrix, term array, allocator and scan port
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "plb_consts.vh"
// Behaviour
// RULE1: matrix routes 36 chosen signals plus complements
// RULE2: 72-input by 87-term product array
// RULE3: 80 general terms shared by 16 macrocells
// RULE4: four enable terms, each pin picks two
// RULE5: upper pins use pair one, lower two; the code gives pins 0-3 terms 80-81 and pins 4-7 terms 82-83
// RULE6: dedicated set and clear terms
// RULE7: last term usable as register clock
// RULE8: control terms have selectable inversion
// RULE9: buried cell registers or latches neighbour pin
// RULE10: buried outputs always feed the matrix
// RULE11: per-pin output polarity selector
// RULE12: feedback path separate from pin input
// RULE13: weak keeper holds last pin level
// RULE14: one slew bit per output
// RULE15: scan port takes five standard instructions
// RULE16: same scan port also reprograms configuration
// RULE17: block is array, allocator, sixteen macrocells
// RULE18: allocator steers terms, sharing only if enabled
module plb_logic_block (
  input  wire                ref_clk,
  input  wire                rst_b,
  input  wire [11:0]         av_address,
  input  wire                av_read,
  input  wire                av_write,
  input  wire [31:0]         av_writedata,
  output reg  [31:0]         av_readdata,
  output reg                 av_waitrequest,
  input  wire [`PLB_NIO-1:0] io_in,
  input  wire [3:0]          ded_in,
  output reg  [`PLB_NIO-1:0] io_out,
  output reg  [`PLB_NIO-1:0] io_oe,
  output reg  [`PLB_NIO-1:0] io_slow,
  output reg  [`PLB_NIO-1:0] io_keep,
  input  wire                jt_tck,
  input  wire                jt_tms,
  input  wire                jt_tdi,
  output reg                 jt_tdo
);
  // tap states
  localparam [3:0] S_EX2DR = 4'h0, S_EX1DR = 4'h1, S_SHDR = 4'h2, S_PDR = 4'h3;
  localparam [3:0] S_SELIR = 4'h4, S_UPDR = 4'h5, S_CAPDR = 4'h6, S_SELDR = 4'h7;
  localparam [3:0] S_EX2IR = 4'h8, S_EX1IR = 4'h9, S_SHIR = 4'ha, S_PIR = 4'hb;
  localparam [3:0] S_RTI = 4'hc, S_UPIR = 4'hd, S_CAPIR = 4'he, S_TLR = 4'hf;

  // configuration storage
  reg [95:0]               term_q [0:`PLB_NPT-1];  // term input masks
  reg [95:0]               alloc_q [0:`PLB_NMC-1]; // term grants per cell
  reg [`PLB_MCFG_W-1:0]    mcfg_q [0:`PLB_NMC-1];  // macrocell options
  reg [4:0]                rsel_q [0:`PLB_NSIG-1]; // matrix selectors
  reg [7:0]                pol_q;                  // polarity and share
  reg [31:0]               user_q;                 // user code
  // pin sampling
  reg [`PLB_NPIN-1:0]      s1_q, s2_q, s3_q, acc_q;
  reg                      pclk_q, ptclk_q, tck_q;
  // scan port
  reg [3:0]                tap_q, tap_d;
  reg [3:0]                ir_q, irs_q;
  reg [`PLB_DR_W-1:0]      dr_q, dr_d;
  reg [15:0]               bsr_q;                  // boundary update stage
  reg                      jpend_q;                // scan config write waiting
  reg [11:0]               jaddr_q;
  reg [31:0]               jdata_q;
  reg [5:0]                len;
  // combinational nets
  wire [`PLB_NIO-1:0]      io_s;
  wire [3:0]               ded_s;
  wire                     tck_s, tms_s, tdi_s;
  wire [`PLB_NSRC-1:0]     src;
  wire [`PLB_NSIG-1:0]     sig;
  wire [`PLB_NIN-1:0]      field;
  wire [`PLB_NPT-1:0]      pt;
  wire [3:0]               oe_t;
  wire                     set_t, clr_t, ptc;
  wire [`PLB_NMC-1:0]      fb, res;
  wire [`PLB_NGEN-1:0]     claim [0:`PLB_NMC];
  wire                     tck_rise, tck_fall;
  wire                     av_req, av_take;
  wire                     wr_en;
  wire [11:0]              wa;
  wire [31:0]              wd;
  reg  [31:0]              rd;
  reg  [`PLB_NIO-1:0]      oe_c;

  assign {tdi_s, tms_s, tck_s, ded_s, io_s} = acc_q;

  // three-flop sampling; a change counts once stages two and three agree
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= {`PLB_NPIN{1'b0}};
      s2_q <= {`PLB_NPIN{1'b0}};
      s3_q <= {`PLB_NPIN{1'b0}};
      acc_q <= {`PLB_NPIN{1'b0}};
    end
    else
    begin
      s1_q <= {jt_tdi, jt_tms, jt_tck, ded_in, io_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      acc_q <= (s2_q & s3_q) | (acc_q & (s2_q | s3_q));
    end
  end

  // sources: pin path and feedback path kept apart
  assign src = {fb, ded_s, io_s}; // [RULE12] [RULE10]

  // routing matrix: 36 selected signals, true and complement
  genvar g;
  generate
    for (g = 0; g < `PLB_NSIG; g = g + 1)
    begin : g_route
      assign sig[g] = (rsel_q[g] < `PLB_NSRC) ? src[rsel_q[g]] : 1'b0; // [RULE1]
    end
  endgenerate
  assign field = {~sig, sig}; // [RULE1] [RULE2]

  // product terms: and of the masked inputs; empty mask gives one
  generate
    for (g = 0; g < `PLB_NPT; g = g + 1)
    begin : g_term
      assign pt[g] = &(~term_q[g][`PLB_NIN-1:0] | field); // [RULE2]
    end
  endgenerate

  // control terms with selectable inversion
  assign oe_t = pt[`PLB_PT_OE0+3:`PLB_PT_OE0] ^ pol_q[3:0]; // [RULE4] [RULE8]
  assign set_t = pt[`PLB_PT_SET] ^ pol_q[`PLB_POL_SET];     // [RULE6] [RULE8]
  assign clr_t = pt[`PLB_PT_CLR] ^ pol_q[`PLB_POL_CLR];     // [RULE6] [RULE8]
  assign ptc = pt[`PLB_PT_CLK] ^ pol_q[`PLB_POL_CLK];       // [RULE7] [RULE8]

  // allocator: lower cells claim a term first unless sharing is on
  assign claim[0] = {`PLB_NGEN{1'b0}};
  generate
    for (g = 0; g < `PLB_NMC; g = g + 1)
    begin : g_mc
      wire [`PLB_NGEN-1:0] grant;
      assign grant = alloc_q[g][`PLB_NGEN-1:0] &
                     (pol_q[`PLB_POL_SHARE] ? {`PLB_NGEN{1'b1}} : ~claim[g]); // [RULE18]
      assign claim[g+1] = claim[g] | alloc_q[g][`PLB_NGEN-1:0];
      // odd cells are buried and watch the pin of their even neighbour
      plb_macrocell u_mc (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .cfg      (mcfg_q[g]),
        .sum      (|(pt[`PLB_NGEN-1:0] & grant)), // [RULE3] [RULE17]
        .pin_in   (io_s[g/2]),
        .set_t    (set_t),
        .clr_t    (clr_t),
        .pin_rise (ded_s[0] & ~pclk_q),
        .pin_lvl  (ded_s[0]),
        .pt_rise  (ptc & ~ptclk_q),
        .pt_lvl   (ptc),
        .state_q  (fb[g]),
        .result   (res[g])
      );
    end
  endgenerate

  // per pin: choose one of the two enable terms of its half
  // one loop index per process, so no variable is driven from two places
  integer k, n, r;
  always @*
  begin
    for (n = 0; n < `PLB_NIO; n = n + 1)
    begin
      if (n < `PLB_NIO / 2)
        oe_c[n] = mcfg_q[2*n][`PLB_MC_OESEL] ? oe_t[1] : oe_t[0]; // [RULE5]
      else
        oe_c[n] = mcfg_q[2*n][`PLB_MC_OESEL] ? oe_t[3] : oe_t[2]; // [RULE5] [RULE4]
    end
  end

  // pin drivers; extest hands the pins to the boundary stage
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_out <= {`PLB_NIO{1'b0}};
      io_oe <= {`PLB_NIO{1'b0}};
      io_slow <= {`PLB_NIO{1'b0}};
      io_keep <= {`PLB_NIO{1'b0}};
      pclk_q <= 1'b0;
      ptclk_q <= 1'b0;
    end
    else
    begin
      pclk_q <= ded_s[0];
      ptclk_q <= ptc;
      for (k = 0; k < `PLB_NIO; k = k + 1)
      begin
        if (ir_q == `PLB_IR_EXTEST)
        begin
          io_out[k] <= bsr_q[k];
          io_oe[k] <= bsr_q[k+`PLB_NIO];
        end
        else
        begin
          io_out[k] <= res[2*k];
          io_oe[k] <= oe_c[k];
        end
        io_slow[k] <= mcfg_q[2*k][`PLB_MC_SLOW]; // [RULE14]
        // keeper follows the driven level, then the pin while released
        io_keep[k] <= io_oe[k] ? io_out[k] : io_s[k]; // [RULE13]
      end
    end
  end

  // avalon slave: one wait cycle, then a one-cycle answer
  assign av_req = av_read | av_write;
  assign av_take = av_req & ~av_waitrequest;
  // the bus has the port while it writes; scan writes wait their turn
  assign wr_en = (av_take & av_write) | jpend_q;
  assign wa = (av_take & av_write) ? av_address : jaddr_q;
  assign wd = (av_take & av_write) ? av_writedata : jdata_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      av_waitrequest <= 1'b1;
      av_readdata <= 32'h0000_0000;
    end
    else if (av_req & av_waitrequest)
    begin
      av_waitrequest <= 1'b0;
      av_readdata <= rd;
    end
    else
      av_waitrequest <= 1'b1;
  end

  // register write decode, shared by bus and scan port
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (r = 0; r < `PLB_NPT; r = r + 1)
        term_q[r] <= 96'h0;
      for (r = 0; r < `PLB_NMC; r = r + 1)
      begin
        alloc_q[r] <= 96'h0;
        mcfg_q[r] <= 7'h00;
      end
      for (r = 0; r < `PLB_NSIG; r = r + 1)
        rsel_q[r] <= 5'h00;
      pol_q <= 8'h00;
      user_q <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      if (wa < `PLB_A_TERM_END && wa[3:2] != 2'h3)
        term_q[wa[10:4]][{wa[3:2], 5'h00} +: 32] <= wd &
          ((wa[3:2] == 2'h2) ? `PLB_TERM_W2_MASK : 32'hffff_ffff);
      else if (wa[11:8] == `PLB_R_ALLOC && wa[3:2] != 2'h3)
        alloc_q[wa[7:4]][{wa[3:2], 5'h00} +: 32] <= wd &
          ((wa[3:2] == 2'h2) ? `PLB_ALLOC_W2_MASK : 32'hffff_ffff);
      else if (wa[11:6] == `PLB_R_MCFG)
        mcfg_q[wa[5:2]] <= wd[`PLB_MCFG_W-1:0];
      else if (wa == `PLB_A_POL)
        pol_q <= wd[7:0];
      else if (wa == `PLB_A_USER)
        user_q <= wd;
      else if (wa[11:8] == `PLB_R_RSEL && wa[7:2] < `PLB_NSIG)
        rsel_q[wa[7:2]] <= wd[4:0];
    end
  end

  // read decode; unmapped and reserved bits read zero
  always @*
  begin
    rd = 32'h0000_0000;
    if (av_address < `PLB_A_TERM_END && av_address[3:2] != 2'h3)
      rd = term_q[av_address[10:4]][{av_address[3:2], 5'h00} +: 32];
    else if (av_address[11:8] == `PLB_R_ALLOC && av_address[3:2] != 2'h3)
      rd = alloc_q[av_address[7:4]][{av_address[3:2], 5'h00} +: 32];
    else if (av_address[11:6] == `PLB_R_MCFG)
      rd = {25'h0, mcfg_q[av_address[5:2]]};
    else if (av_address == `PLB_A_POL)
      rd = {24'h0, pol_q};
    else if (av_address == `PLB_A_USER)
      rd = user_q;
    else if (av_address[11:8] == `PLB_R_RSEL && av_address[7:2] < `PLB_NSIG)
      rd = {27'h0, rsel_q[av_address[7:2]]};
    else if (av_address == `PLB_A_PINS)
      rd = {20'h0, ded_s, io_s};
    else if (av_address == `PLB_A_MCST)
      rd = {16'h0, fb};
  end

  // scan port: tck sampled at core rate
  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // tap next state
  always @*
  begin
    case (tap_q)
      S_TLR:   tap_d = tms_s ? S_TLR : S_RTI;
      S_RTI:   tap_d = tms_s ? S_SELDR : S_RTI;
      S_SELDR: tap_d = tms_s ? S_SELIR : S_CAPDR;
      S_CAPDR: tap_d = tms_s ? S_EX1DR : S_SHDR;
      S_SHDR:  tap_d = tms_s ? S_EX1DR : S_SHDR;
      S_EX1DR: tap_d = tms_s ? S_UPDR : S_PDR;
      S_PDR:   tap_d = tms_s ? S_EX2DR : S_PDR;
      S_EX2DR: tap_d = tms_s ? S_UPDR : S_SHDR;
      S_UPDR:  tap_d = tms_s ? S_SELDR : S_RTI;
      S_SELIR: tap_d = tms_s ? S_TLR : S_CAPIR;
      S_CAPIR: tap_d = tms_s ? S_EX1IR : S_SHIR;
      S_SHIR:  tap_d = tms_s ? S_EX1IR : S_SHIR;
      S_EX1IR: tap_d = tms_s ? S_UPIR : S_PIR;
      S_PIR:   tap_d = tms_s ? S_EX2IR : S_PIR;
      S_EX2IR: tap_d = tms_s ? S_UPIR : S_SHIR;
      default: tap_d = tms_s ? S_SELDR : S_RTI;
    endcase
  end

  // data register length per instruction; unknown codes act as bypass
  always @*
  begin
    case (ir_q)
      `PLB_IR_EXTEST, `PLB_IR_SAMPLE: len = `PLB_LEN_BSR; // [RULE15]
      `PLB_IR_IDCODE, `PLB_IR_USER:   len = `PLB_LEN_ID;  // [RULE15]
      `PLB_IR_CFG:                    len = `PLB_LEN_CFG; // [RULE16]
      default:                        len = `PLB_LEN_BYP; // [RULE15]
    endcase
    dr_d = {1'b0, dr_q[`PLB_DR_W-1:1]};
    dr_d[len-6'd1] = tdi_s;
  end

  // tap registers advance on sampled tck rise, tdo moves on its fall
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tck_q <= 1'b0;
      tap_q <= S_TLR;
      ir_q <= `PLB_IR_IDCODE;
      irs_q <= 4'h0;
      dr_q <= {`PLB_DR_W{1'b0}};
      bsr_q <= 16'h0000;
      jpend_q <= 1'b0;
      jaddr_q <= 12'h000;
      jdata_q <= 32'h0000_0000;
      jt_tdo <= 1'b0;
    end
    else
    begin
      tck_q <= tck_s;
      // a pending scan write lands once the bus leaves the port free
      if (jpend_q & ~(av_take & av_write))
        jpend_q <= 1'b0;
      if (tck_fall)
        jt_tdo <= (tap_q == S_SHIR) ? irs_q[0] : dr_q[0];
      if (tck_rise)
      begin
        tap_q <= tap_d;
        case (tap_q)
          S_TLR:   ir_q <= `PLB_IR_IDCODE;
          S_CAPIR: irs_q <= `PLB_IR_CAPT;
          S_SHIR:  irs_q <= {tdi_s, irs_q[3:1]};
          S_UPIR:  ir_q <= irs_q; // [RULE15]
          S_SHDR:  dr_q <= dr_d;
          S_CAPDR:
          begin
            if (ir_q == `PLB_IR_EXTEST || ir_q == `PLB_IR_SAMPLE)
              dr_q <= {28'h0, io_oe, io_s}; // [RULE15]
            else if (ir_q == `PLB_IR_IDCODE)
              dr_q <= {12'h000, `PLB_IDCODE}; // [RULE15]
            else if (ir_q == `PLB_IR_USER)
              dr_q <= {12'h000, user_q}; // [RULE15]
            else
              dr_q <= {`PLB_DR_W{1'b0}};
          end
          S_UPDR:
          begin
            if (ir_q == `PLB_IR_EXTEST || ir_q == `PLB_IR_SAMPLE)
              bsr_q <= dr_q[15:0]; // [RULE15]
            else if (ir_q == `PLB_IR_CFG)
            begin
              jpend_q <= 1'b1; // [RULE16]
              jaddr_q <= dr_q[43:32];
              jdata_q <= dr_q[31:0];
            end
          end
          default: irs_q <= irs_q;
        endcase
      end
    end
  end
endmodule

// File: sim/plb_checker.sv
// assertions on the logic block bus, pin and scan ports
`timescale 1ns/100ps
`include "plb_consts.vh"
module plb_checker (
  input wire                ref_clk,
  input wire                rst_b,
  input wire [11:0]         av_address,
  input wire                av_read,
  input wire                av_write,
  input wire [31:0]         av_readdata,
  input wire                av_waitrequest,
  input wire [`PLB_NIO-1:0] io_out,
  input wire [`PLB_NIO-1:0] io_oe,
  input wire [`PLB_NIO-1:0] io_keep,
  input wire                jt_tck,
  input wire                jt_tdo
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // a request seen with the stall high is answered at the next edge
  chk_req_answer: assert property ((av_read || av_write) && av_waitrequest |=> !av_waitrequest)
    else $error("request not answered after one wait cycle");
  // the answer lasts a single cycle
  chk_wait_pulse: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // no answer without a request behind it
  chk_no_spurious: assert property ($fell(av_waitrequest) |-> $past(av_read || av_write))
    else $error("answer without a request");
  // read data stand until the next answer
  chk_rdata_stands: assert property (av_waitrequest |-> $stable(av_readdata))
    else $error("read data changed outside an answer");
  // an unmapped place reads as zero
  chk_unmapped_zero: assert property (av_read && !av_waitrequest && av_address == 12'hffc |-> av_readdata == 32'h0)
    else $error("unmapped read not zero");
  // while driven and quiet, the keeper tracks the driven level
  chk_keep_follow: assert property (($stable(io_out) && $stable(io_oe)) [*6] |-> ((io_keep ^ io_out) & io_oe) == 8'h00)
    else $error("keeper does not hold driven level");
  // scan output moves only after the scan clock has fallen
  chk_tdo_on_fall: assert property ($changed(jt_tdo) |-> !$past(jt_tck, 2))
    else $error("scan output changed while scan clock high");
  // leaving reset the bus is idle and no pin is driven
  chk_reset_idle: assert property ($rose(rst_b) |-> av_waitrequest && io_oe == 8'h00 && jt_tdo == 1'b0)
    else $error("outputs not idle after reset");
endmodule

bind plb_logic_block plb_checker plb_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b), .av_address(av_address),
  .av_read(av_read), .av_write(av_write), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
  .io_out(io_out), .io_oe(io_oe), .io_keep(io_keep), .jt_tck(jt_tck), .jt_tdo(jt_tdo));

// File: sim/plb_board.sv
// board model: resolves each pin from device drive, board drive and keeper
`timescale 1ns/100ps
`include "plb_consts.vh"
module plb_board (
  input  wire [`PLB_NIO-1:0] io_out,  // device output level
  input  wire [`PLB_NIO-1:0] io_oe,   // device drives pin
  input  wire [`PLB_NIO-1:0] io_keep, // device keeper level
  input  wire [`PLB_NIO-1:0] drv_en,  // board drives pin
  input  wire [`PLB_NIO-1:0] drv_val, // board drive level
  output wire [`PLB_NIO-1:0] pin      // level seen on each pin
);
  // device drive wins; an undriven pin sits at the keeper level,
  // never at a stale board value after the board lets go
  assign pin = (io_oe & io_out) | (~io_oe & drv_en & drv_val) | (~io_oe & ~drv_en & io_keep);
endmodule

// File: sim/plb_logic_block_tb_top.sv
// self-checking bench for the logic block
`timescale 1ns/100ps
`include "plb_consts.vh"
module plb_logic_block_tb_top;
  logic        ref_clk, rst_b;          // clock and active-low reset
  logic [11:0] av_address;              // bus address
  logic        av_read, av_write;       // bus requests
  logic [31:0] av_writedata;            // bus write data
  wire  [31:0] av_readdata;             // bus read data
  wire         av_waitrequest;          // bus stall
  wire  [7:0]  io_in;                   // resolved pin levels
  logic [3:0]  ded_in;                  // dedicated inputs
  wire  [7:0]  io_out, io_oe, io_slow, io_keep; // pin side outputs
  logic        jt_tck, jt_tms, jt_tdi;  // scan inputs
  wire         jt_tdo;                  // scan output
  logic [7:0]  drv_en, drv_val;         // board drive per pin
  int          err_total, comparisons, cyc; // counters
  plb_logic_block plb_logic_block_inst (.ref_clk(ref_clk), .rst_b(rst_b), .av_address(av_address),
    .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .io_in(io_in), .ded_in(ded_in), .io_out(io_out), .io_oe(io_oe),
    .io_slow(io_slow), .io_keep(io_keep), .jt_tck(jt_tck), .jt_tms(jt_tms), .jt_tdi(jt_tdi), .jt_tdo(jt_tdo));
  plb_board plb_board_inst (.io_out(io_out), .io_oe(io_oe), .io_keep(io_keep), .drv_en(drv_en),
    .drv_val(drv_val), .pin(io_in));
  // 4 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      conclude;
    end
  end
  // compare and count; four-state so unknowns never match
  task eq(input logic [43:0] got, input logic [43:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until the stall is seen low
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    av_address   <= a;
    av_writedata <= d;
    av_write     <= w;
    av_read      <= !w;
    @(posedge ref_clk);
    while (av_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = av_readdata;
    av_write <= 1'b0;
    av_read  <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  // write, read back, compare
  task rw(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b1, a, d, q);
    acc(1'b0, a, 32'h0, q);
    eq(q, e);
  endtask
  // pins pass three sync flops plus output register, so allow margin
  task settle;
    repeat (10) @(posedge ref_clk);
  endtask
  // one scan clock; each level held well over four system clocks
  task tick(input logic ms, input logic di, output logic dout);
    @(posedge ref_clk);
    dout = jt_tdo;
    jt_tms <= ms;
    jt_tdi <= di;
    repeat (6) @(posedge ref_clk);
    jt_tck <= 1'b1;
    repeat (8) @(posedge ref_clk);
    jt_tck <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // walk the scan state machine, select bits first bit first
  task path(input logic [3:0] ms, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      tick(ms[i], 1'b0, b);
  endtask
  // shift n bits; the last one leaves the shift state
  task shift(input logic [43:0] din, input int n, output logic [43:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  // data scan from idle back to idle
  task dr(input logic [43:0] din, input int n, output logic [43:0] dout);
    path(4'b0001, 3);
    shift(din, n, dout);
    path(4'b0001, 2);
  endtask
  // instruction scan from idle back to idle
  task ir(input logic [3:0] code);
    logic [43:0] d;
    path(4'b0011, 4);
    shift({40'h0, code}, 4, d);
    path(4'b0001, 2);
  endtask
  // register widths, counts and unmapped places
  task t_regs;
    rw(12'h008, 32'hffff_ffff, 32'h0000_00ff);
    rw(12'h568, 32'hffff_ffff, 32'h0000_00ff);
    rw(12'h568, 32'h0, 32'h0);
    rw(12'h570, 32'hffff_ffff, 32'h0);
    rw(12'h6f8, 32'hffff_ffff, 32'h0000_ffff);
    rw(12'h73c, 32'hffff_ffff, 32'h0000_007f);
    rw(12'h98c, 32'hffff_ffff, 32'h0000_001f);
    rw(12'h990, 32'hffff_ffff, 32'h0);
    rw(12'hffc, 32'h1234_5678, 32'h0);
    $display("t_regs done");
  endtask
  // pin 1 routed through term 0 to cells 0 and 2
  task t_logic;
    logic [31:0] q;
    drv_en  <= 8'h0e;
    drv_val <= 8'h02;
    wr(12'h900, 32'h1);
    wr(12'h000, 32'h1);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
    wr(12'h600, 32'h1);
    wr(12'h620, 32'h1);
    wr(12'h700, 32'h8);
    wr(12'h740, 32'h31);
    settle;
    eq(io_oe, 8'hf1);
    eq(io_out[1:0], 2'b01);
    wr(12'h740, 32'hb1);
    settle;
    eq(io_out[1:0], 2'b11);
    drv_val <= 8'h00;
    settle;
    eq(io_out[1:0], 2'b00);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h10);
    settle;
    eq(io_out[0], 1'b1);
    wr(12'h700, 32'h2c);
    drv_val <= 8'h02;
    ded_in  <= 4'ha;
    settle;
    eq({io_slow, io_out[0]}, {8'h01, 1'b1});
    acc(1'b0, 12'ha00, 32'h0, q);
    eq(q[11:0], 12'ha03);
    wr(12'h740, 32'h85);
    settle;
    eq(io_oe, 8'h01);
    wr(12'h740, 32'h87);
    settle;
    eq({io_oe, io_keep[0]}, {8'h00, 1'b1});
    $display("t_logic done");
  endtask
  // buried cell 1 as input register of pin 0, clocked by term 86
  task t_buried;
    logic [31:0] q;
    wr(12'h704, 32'h51);
    settle;
    acc(1'b0, 12'ha04, 32'h0, q);
    eq(q[1], 1'b0);
    wr(12'h740, 32'ha7);
    settle;
    acc(1'b0, 12'ha04, 32'h0, q);
    eq(q[1], 1'b1);
    drv_en  <= 8'h0f;
    drv_val <= 8'h02;
    wr(12'h740, 32'hb7);
    wr(12'h740, 32'hf7);
    settle;
    wr(12'h740, 32'hb7);
    settle;
    acc(1'b0, 12'ha04, 32'h0, q);
    eq(q[1], 1'b0);
    $display("t_buried done");
  endtask
  // every scan instruction once, plus a write through the scan port
  task t_scan;
    logic [43:0] d;
    logic [31:0] q;
    path(4'b0000, 1);
    dr(44'h0, 32, d);
    eq(d[31:0], `PLB_IDCODE);
    ir(`PLB_IR_CFG);
    dr({12'h744, 32'h5a5a_0c3c}, 44, d);
    settle;
    acc(1'b0, 12'h744, 32'h0, q);
    eq(q, 32'h5a5a_0c3c);
    ir(`PLB_IR_USER);
    dr(44'h0, 32, d);
    eq(d[31:0], 32'h5a5a_0c3c);
    ir(`PLB_IR_BYPASS);
    dr(44'h1, 2, d);
    eq(d[1:0], 2'b10);
    ir(`PLB_IR_SAMPLE);
    dr({28'h0, 16'hffa5}, 16, d);
    eq(d[15:0], 16'h0002);
    ir(`PLB_IR_EXTEST);
    dr({28'h0, 16'hffa5}, 16, d);
    settle;
    eq({io_oe, io_out}, 16'hffa5);
    $display("t_scan done");
  endtask
  // counts, verdict, end of run
  task conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset for two cycles, then the scenarios in turn
  initial
  begin
    rst_b = 1'b0;
    {av_address, av_read, av_write, av_writedata} = '0;
    {ded_in, jt_tck, jt_tms, jt_tdi, drv_en, drv_val} = '0;
    {err_total, comparisons, cyc} = '0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_logic;
    t_buried;
    t_scan;
    conclude;
  end
endmodule
